// [design/modem_cfg_pkg.sv]
// Command codes, setting limits, reset values and timing for the
// command-mode settings block of the serial-to-radio modem.
// Assumes a 125 MHz module clock; no other file defines these names.
package modem_cfg_pkg;

  // Binary command codes.
  localparam logic [7:0] CMD_WAKE_DELAY = 8'h03;
  localparam logic [7:0] CMD_SOFT_FLOW  = 8'h07;
  localparam logic [7:0] CMD_ECHO_OFF   = 8'h0A;
  localparam logic [7:0] CMD_ECHO_ON    = 8'h0B;
  localparam logic [7:0] CMD_WAKE_LEN   = 8'h0C;
  localparam logic [7:0] CMD_FORCE_WAKE = 8'h0D;
  localparam logic [7:0] CMD_ERR_CNT    = 8'h0F;
  localparam logic [7:0] CMD_GOOD_CNT   = 8'h10;
  localparam logic [7:0] CMD_HOP        = 8'h11;
  localparam logic [7:0] CMD_FLOW_THR   = 8'h24;
  localparam logic [7:0] CMD_NET_ID     = 8'h27;
  localparam logic [7:0] CMD_KEY        = 8'h3C;
  localparam logic [7:0] CMD_SYNC       = 8'h3E;

  // Software flow control characters.
  localparam logic [7:0] XON_CHAR  = 8'h11;
  localparam logic [7:0] XOFF_CHAR = 8'h13;

  // Limits and reset values of the settings.
  localparam logic [15:0] ZERO16         = 16'h0000;
  localparam logic [15:0] ONE16          = 16'h0001;
  localparam logic [15:0] CNT_MAX        = 16'hFFFF;
  localparam logic [15:0] WAKE_OFF       = 16'hFFFF;
  localparam logic [15:0] SOFT_FLOW_MAX  = 16'h0001;
  localparam logic [15:0] HOP_MAX        = 16'h0009;
  localparam logic [15:0] WAKE_LEN_MAX   = 16'h00FF;
  localparam logic [15:0] NET_ID_MIN     = 16'h0011;
  localparam logic [15:0] NET_ID_MAX     = 16'h7FFF;
  // Default network identifier; the value is arbitrary.
  localparam logic [15:0] NET_ID_DEFAULT = 16'h0123;
  localparam logic [15:0] RX_BUF_BYTES   = 16'h0100;
  localparam logic [15:0] FLOW_MARGIN    = 16'h0011;
  localparam logic [15:0] FLOW_THR_DEF   = RX_BUF_BYTES - FLOW_MARGIN;
  localparam logic [7:0]  WAKE_LEN_DEF   = 8'h01;
  localparam logic [6:0]  KEY_DIGITS     = 7'h40;
  localparam logic [7:0]  IV_EXTRA_BYTES = 8'h10;

  // Timing: one base tick every 10 ms, the idle unit is 100 ms.
  localparam int TICK_MS     = 10;
  localparam int IDLE_MS     = 100;
  localparam int CLK_KHZ     = 125000;
  localparam int TICK_CYCLES = TICK_MS * CLK_KHZ;
  localparam int TICK_W      = 21;
  localparam logic [3:0] IDLE_TICKS = 4'(IDLE_MS / TICK_MS);

  // One parsed command from the host.
  typedef struct packed {
    logic [7:0]  code;
    logic        has_arg;
    logic [15:0] arg;
  } cmd_t;

  // Answer to one command.
  typedef struct packed {
    logic        valid;
    logic        err;
    logic [15:0] data;
  } resp_t;

endpackage

// [design/char_skid_buffer.sv]
// Two-entry buffer with valid and ready on both sides.
// Assumes one clock; every output comes from a flip-flop.
`timescale 1ns/10ps
module char_skid_buffer #(
  parameter int WIDTH = 8
) (
  input  wire logic             mclk_i,
  input  wire logic             reset_i,
  input  wire logic             ce_i,
  input  wire logic             in_valid_i,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  in_ready_o,
  output logic                  out_valid_o,
  output logic      [WIDTH-1:0] out_data_o,
  input  wire logic             out_ready_i
);

  logic [WIDTH-1:0] spare;
  logic             spare_valid;
  logic             push;
  logic             out_free;

  // Accept while the spare slot is empty; free the head on a pop.
  assign push     = in_valid_i & ~spare_valid;
  assign out_free = ~out_valid_o | out_ready_i;
  assign in_ready_o = ~spare_valid;

  // The head moves on when drained; the spare catches a stalled word.
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      out_valid_o <= 1'b0;
      out_data_o  <= '0;
      spare_valid <= 1'b0;
      spare       <= '0;
    end else if (ce_i) begin
      if (out_free) begin
        out_valid_o <= spare_valid | push;
        out_data_o  <= spare_valid ? spare : in_data_i;
        spare_valid <= spare_valid & push;
        spare       <= in_data_i;
      end else if (push) begin
        spare_valid <= 1'b1;
        spare       <= in_data_i;
      end
    end
  end

  // A held word must stay put until taken.
  a_head_hold: assert property (@(posedge mclk_i) disable iff (reset_i)
    out_valid_o & ~out_ready_i |=> out_valid_o & $stable(out_data_o))
    else $error("buffer head changed while stalled");

  c_buffer_full: cover property (@(posedge mclk_i) disable iff (reset_i)
    spare_valid & out_valid_o);

endmodule // char_skid_buffer

// [design/modem_cmd_settings.sv]
// Command-mode settings of the serial-to-radio modem: echo, packet
// counters, flow control, initializer timing, filtering and key.
// Assumes commands arrive already parsed, all inputs are synchronous.
`timescale 1ns/10ps
module modem_cmd_settings #(
  parameter int TICK_CYCLES = modem_cfg_pkg::TICK_CYCLES
) (
  input  wire logic                 mclk_i,
  input  wire logic                 reset_i,
  input  wire logic                 ce_i,
  input  wire logic                 cmd_valid_i,
  input  wire modem_cfg_pkg::cmd_t  cmd_i,
  input  wire logic [6:0]           key_digits_i,
  input  wire logic [255:0]         key_value_i,
  output modem_cfg_pkg::resp_t      resp_o,
  input  wire logic                 cmd_mode_i,
  input  wire logic                 char_valid_i,
  input  wire logic [7:0]           char_i,
  output logic                      char_ready_o,
  output logic                      echo_valid_o,
  output logic [7:0]                echo_char_o,
  input  wire logic                 echo_ready_i,
  input  wire logic [15:0]          rx_fill_i,
  output logic                      flow_output_pin_n_o,
  output logic                      flow_char_valid_o,
  output logic [7:0]                flow_char_o,
  input  wire logic                 rx_error_evt_i,
  input  wire logic                 rx_good_evt_i,
  input  wire logic                 stream_active_i,
  input  wire logic                 stream_gap_i,
  input  wire logic                 activity_i,
  input  wire logic                 tx_start_i,
  output logic                      init_full_o,
  output logic                      init_wakeup_o,
  output logic [7:0]                wake_len_o,
  input  wire logic                 peer_valid_i,
  input  wire logic [3:0]           peer_channel_i,
  input  wire logic [15:0]          peer_id_i,
  output logic                      peer_accept_o,
  input  wire logic                 sleep_cyclic_i,
  input  wire logic                 sleep_interval_i,
  input  wire logic                 wake_detect_i,
  output logic                      listen_o,
  output logic                      stay_awake_o,
  output logic [3:0]                hop_channel_o,
  output logic [15:0]               network_identifier_o,
  output logic                      encrypt_en_o,
  output logic [255:0]              cipher_key_o,
  output logic [7:0]                iv_extra_o
);

  logic        echo_on;
  logic [15:0] rx_error_counter;
  logic [15:0] rx_good_counter;
  logic        soft_flow_enable;
  logic [15:0] forced_sync_period;
  logic [15:0] flow_threshold;
  logic [15:0] wakeup_idle_delay;
  logic        flow_hold;
  logic        need_full;
  logic        need_wake;
  logic [modem_cfg_pkg::TICK_W-1:0] tick_cnt;
  logic [3:0]  idle_sub;
  logic [15:0] idle_cnt;
  logic [15:0] sync_cnt;

  // Command decode.
  wire [7:0]  code   = cmd_i.code;
  wire [15:0] arg    = cmd_i.arg;
  wire        is_wr  = cmd_valid_i & cmd_i.has_arg;
  wire        is_rd  = cmd_valid_i & ~cmd_i.has_arg;
  wire        c_eoff = code == modem_cfg_pkg::CMD_ECHO_OFF;
  wire        c_eon  = code == modem_cfg_pkg::CMD_ECHO_ON;
  wire        c_err  = code == modem_cfg_pkg::CMD_ERR_CNT;
  wire        c_good = code == modem_cfg_pkg::CMD_GOOD_CNT;
  wire        c_frc  = code == modem_cfg_pkg::CMD_FORCE_WAKE;
  wire        c_sfl  = code == modem_cfg_pkg::CMD_SOFT_FLOW;
  wire        c_syn  = code == modem_cfg_pkg::CMD_SYNC;
  wire        c_thr  = code == modem_cfg_pkg::CMD_FLOW_THR;
  wire        c_hop  = code == modem_cfg_pkg::CMD_HOP;
  wire        c_dly  = code == modem_cfg_pkg::CMD_WAKE_DELAY;
  wire        c_wln  = code == modem_cfg_pkg::CMD_WAKE_LEN;
  wire        c_nid  = code == modem_cfg_pkg::CMD_NET_ID;
  wire        c_key  = code == modem_cfg_pkg::CMD_KEY;
  wire        c_known = c_eoff | c_eon | c_err | c_good | c_frc | c_sfl |
                        c_syn | c_thr | c_hop | c_dly | c_wln | c_nid | c_key;

  // Key argument check: exactly 64 digits, or a zero value.
  wire key_zero = key_value_i == '0;
  wire key_ok   = (key_digits_i == modem_cfg_pkg::KEY_DIGITS) |
                  (key_digits_i != 7'h00 & key_zero);
  wire key_bad  = c_key & (~cmd_i.has_arg | ~key_ok);

  // Range checks on written values.
  wire id_bad  = arg < modem_cfg_pkg::NET_ID_MIN |
                 arg > modem_cfg_pkg::NET_ID_MAX;
  wire rng_bad = (c_sfl & arg > modem_cfg_pkg::SOFT_FLOW_MAX) |
                 (c_hop & arg > modem_cfg_pkg::HOP_MAX) |
                 (c_nid & id_bad) |
                 (c_thr & arg > modem_cfg_pkg::FLOW_THR_DEF) |
                 (c_wln & arg > modem_cfg_pkg::WAKE_LEN_MAX);
  wire cmd_bad = cmd_valid_i &
                 (~c_known | key_bad | (cmd_i.has_arg & rng_bad));
  wire wr_ok   = is_wr & ~cmd_bad;
  wire wr_err  = wr_ok & c_err;
  wire wr_good = wr_ok & c_good;

  // Read data selection; the key has no read path.
  wire [15:0] rd_data =
    c_err  ? rx_error_counter :
    c_good ? rx_good_counter :
    c_sfl  ? {15'h0000, soft_flow_enable} :
    c_syn  ? forced_sync_period :
    c_thr  ? flow_threshold :
    c_hop  ? {12'h000, hop_channel_o} :
    c_dly  ? wakeup_idle_delay :
    c_wln  ? {8'h00, wake_len_o} :
    c_nid  ? network_identifier_o :
             modem_cfg_pkg::ZERO16;

  // Answer to each command, one cycle after it is taken.
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      resp_o <= '0;
    end else if (ce_i) begin
      resp_o.valid <= cmd_valid_i;
      resp_o.err   <= cmd_bad;
      resp_o.data  <= is_rd & ~cmd_bad ? rd_data : modem_cfg_pkg::ZERO16;
    end
  end

  // Echo and simple settings written by commands.
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      echo_on              <= 1'b0;
      soft_flow_enable     <= 1'b0;
      forced_sync_period   <= modem_cfg_pkg::ZERO16;
      flow_threshold       <= modem_cfg_pkg::FLOW_THR_DEF;
      wakeup_idle_delay    <= modem_cfg_pkg::WAKE_OFF;
      wake_len_o           <= modem_cfg_pkg::WAKE_LEN_DEF;
      hop_channel_o        <= 4'h0;
      network_identifier_o <= modem_cfg_pkg::NET_ID_DEFAULT;
    end else if (ce_i) begin
      if (cmd_valid_i & c_eoff) echo_on <= 1'b0;
      if (cmd_valid_i & c_eon) echo_on <= 1'b1;
      if (wr_ok & c_sfl) soft_flow_enable <= arg[0];
      if (wr_ok & c_syn) forced_sync_period <= arg;
      if (wr_ok & c_thr) flow_threshold <= arg;
      if (wr_ok & c_dly) wakeup_idle_delay <= arg;
      if (wr_ok & c_wln) wake_len_o <= arg[7:0];
      if (wr_ok & c_hop) hop_channel_o <= arg[3:0];
      if (wr_ok & c_nid) network_identifier_o <= arg;
    end
  end

  // Key storage; the cipher engine is the only reader.
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      cipher_key_o <= '0;
      encrypt_en_o <= 1'b0;
      iv_extra_o   <= 8'h00;
    end else if (ce_i & wr_ok & c_key) begin
      cipher_key_o <= key_value_i;
      encrypt_en_o <= ~key_zero;
      iv_extra_o   <= key_zero ? 8'h00 : modem_cfg_pkg::IV_EXTRA_BYTES;
    end
  end

  // Packet counters saturate; a host write overrides an event.
  wire err_max  = rx_error_counter == modem_cfg_pkg::CNT_MAX;
  wire good_max = rx_good_counter == modem_cfg_pkg::CNT_MAX;
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      rx_error_counter <= modem_cfg_pkg::ZERO16;
      rx_good_counter  <= modem_cfg_pkg::ZERO16;
    end else if (ce_i) begin
      if (wr_err) rx_error_counter <= arg;
      else if (rx_error_evt_i & ~err_max)
        rx_error_counter <= rx_error_counter + modem_cfg_pkg::ONE16;
      if (wr_good) rx_good_counter <= arg;
      else if (rx_good_evt_i & ~good_max)
        rx_good_counter <= rx_good_counter + modem_cfg_pkg::ONE16;
    end
  end

  // Echo path: characters go through the two-entry buffer.
  wire echo_push = cmd_mode_i & echo_on & char_valid_i;
  char_skid_buffer #(
    .WIDTH (8)
  ) u_echo_buf (
    .mclk_i      (mclk_i),
    .reset_i     (reset_i),
    .ce_i        (ce_i),
    .in_valid_i  (echo_push),
    .in_data_i   (char_i),
    .in_ready_o  (char_ready_o),
    .out_valid_o (echo_valid_o),
    .out_data_o  (echo_char_o),
    .out_ready_i (echo_ready_i)
  );

  // Flow control against the receive buffer fill level.
  wire over = rx_fill_i >= flow_threshold;
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      flow_hold           <= 1'b0;
      flow_output_pin_n_o <= 1'b0;
      flow_char_valid_o   <= 1'b0;
      flow_char_o         <= 8'h00;
    end else if (ce_i) begin
      flow_hold           <= over;
      flow_output_pin_n_o <= over & ~soft_flow_enable;
      flow_char_valid_o   <= soft_flow_enable & (over ^ flow_hold);
      flow_char_o         <= over ? modem_cfg_pkg::XOFF_CHAR
                                  : modem_cfg_pkg::XON_CHAR;
    end
  end

  // Base tick every 10 ms and a 100 ms sub-count for idle time.
  wire tick     = tick_cnt == modem_cfg_pkg::TICK_W'(TICK_CYCLES - 1);
  wire idle_inc = tick & (idle_sub == modem_cfg_pkg::IDLE_TICKS - 4'h1);
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      tick_cnt <= '0;
      idle_sub <= 4'h0;
    end else if (ce_i) begin
      tick_cnt <= tick ? '0 : tick_cnt + 1'b1;
      if (activity_i | idle_inc) idle_sub <= 4'h0;
      else if (tick) idle_sub <= idle_sub + 4'h1;
    end
  end

  // Initializer requests: set wins over the clear at transmit start.
  wire wake_on   = wakeup_idle_delay != modem_cfg_pkg::WAKE_OFF;
  wire idle_due  = wake_on & idle_cnt >= wakeup_idle_delay;
  wire force_set = cmd_valid_i & c_frc & wake_on;
  wire sync_due  = stream_active_i &
                   forced_sync_period != modem_cfg_pkg::ZERO16 &
                   sync_cnt >= forced_sync_period;
  wire full_set  = ~stream_active_i | stream_gap_i | sync_due;
  wire wake_set  = force_set | idle_due;
  wire next_full = full_set | (need_full & ~tx_start_i);
  wire next_wake = wake_set | (need_wake & ~tx_start_i);
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      need_full     <= 1'b1;
      need_wake     <= 1'b0;
      init_full_o   <= 1'b0;
      init_wakeup_o <= 1'b0;
    end else if (ce_i) begin
      need_full     <= next_full;
      need_wake     <= next_wake;
      init_full_o   <= tx_start_i & (need_full | full_set);
      init_wakeup_o <= tx_start_i & (need_wake | wake_set);
    end
  end

  // Idle time in 100 ms units and sync time in 10 ms units.
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      idle_cnt <= modem_cfg_pkg::ZERO16;
      sync_cnt <= modem_cfg_pkg::ZERO16;
    end else if (ce_i) begin
      if (activity_i | idle_due) idle_cnt <= modem_cfg_pkg::ZERO16;
      else if (idle_inc & idle_cnt != modem_cfg_pkg::CNT_MAX)
        idle_cnt <= idle_cnt + modem_cfg_pkg::ONE16;
      if (~stream_active_i | sync_due) sync_cnt <= modem_cfg_pkg::ZERO16;
      else if (tick & sync_cnt != modem_cfg_pkg::CNT_MAX)
        sync_cnt <= sync_cnt + modem_cfg_pkg::ONE16;
    end
  end

  // Peer filtering and cyclic sleep listening.
  wire peer_match = peer_channel_i == hop_channel_o &
                    peer_id_i == network_identifier_o;
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      peer_accept_o <= 1'b0;
      listen_o      <= 1'b0;
      stay_awake_o  <= 1'b0;
    end else if (ce_i) begin
      peer_accept_o <= peer_valid_i & peer_match;
      listen_o      <= sleep_cyclic_i & sleep_interval_i;
      if (~sleep_cyclic_i) stay_awake_o <= 1'b0;
      else if (listen_o & wake_detect_i) stay_awake_o <= 1'b1;
    end
  end

  // Checks on the logic above.
  a_echo_off_cmd: assert property (@(posedge mclk_i)
    disable iff (reset_i) ce_i & cmd_valid_i & c_eoff |=> ~echo_on)
    else $error("echo still on after echo-off command");

  a_echo_out: assert property (@(posedge mclk_i) disable iff (reset_i)
    ce_i & echo_push & char_ready_o |=> echo_valid_o)
    else $error("echoed character did not appear");

  a_err_incr: assert property (@(posedge mclk_i) disable iff (reset_i)
    ce_i & rx_error_evt_i & ~err_max & ~wr_err |=>
    rx_error_counter == $past(rx_error_counter) + 16'h0001)
    else $error("error counter did not step by one");

  a_err_sat: assert property (@(posedge mclk_i) disable iff (reset_i)
    err_max & ~(ce_i & wr_err) |=> err_max)
    else $error("error counter left its maximum");

  a_good_incr: assert property (@(posedge mclk_i) disable iff (reset_i)
    ce_i & rx_good_evt_i & ~good_max & ~wr_good |=>
    rx_good_counter == $past(rx_good_counter) + 16'h0001)
    else $error("good counter did not step by one");

  a_good_sat: assert property (@(posedge mclk_i) disable iff (reset_i)
    good_max & ~(ce_i & wr_good) |=> good_max)
    else $error("good counter left its maximum");

  a_wake_off: assert property (@(posedge mclk_i) disable iff (reset_i)
    ~wake_on & ~need_wake & ~(ce_i & wr_ok & c_dly) |=> ~need_wake)
    else $error("wake-up initializer requested while disabled");

  a_cts_thresh: assert property (@(posedge mclk_i) disable iff (reset_i)
    ce_i & over & ~soft_flow_enable |=> flow_output_pin_n_o)
    else $error("flow pin not raised at threshold");

  a_hop_range: assert property (@(posedge mclk_i) disable iff (reset_i)
    hop_channel_o <= 4'h9)
    else $error("hop channel out of range");

  a_id_range: assert property (@(posedge mclk_i) disable iff (reset_i)
    ce_i & wr_ok & c_nid |=> network_identifier_o >= 16'h0011 &
    network_identifier_o <= 16'h7FFF)
    else $error("network identifier out of user range");

  a_key_reject: assert property (@(posedge mclk_i) disable iff (reset_i)
    ce_i & cmd_valid_i & c_key & ~key_ok |=> resp_o.valid & resp_o.err)
    else $error("bad key argument not rejected");

  c_echo_stall: cover property (@(posedge mclk_i) disable iff (reset_i)
    echo_valid_o & ~echo_ready_i ##1 ~char_ready_o);
  c_xoff_sent: cover property (@(posedge mclk_i) disable iff (reset_i)
    flow_char_valid_o & flow_char_o == 8'h13);
  c_wake_sent: cover property (@(posedge mclk_i) disable iff (reset_i)
    init_wakeup_o);
  c_stay_awake: cover property (@(posedge mclk_i) disable iff (reset_i)
    $rose(stay_awake_o));

endmodule // modem_cmd_settings

// [tb/echo_sink_model.sv]
// Model of the host terminal that takes echoed command-mode characters.
// Assumes one clock; when slow_i is high it is ready every other cycle.
`timescale 1ns/10ps
module echo_sink_model (
  input  wire logic        mclk_i,
  input  wire logic        reset_i,
  input  wire logic        slow_i,
  input  wire logic        valid_i,
  input  wire logic [7:0]  char_i,
  output logic             ready_o,
  output logic [7:0]       count_o,
  output logic [15:0]      sum_o
);
  // Stalls on alternate cycles when slow, and keeps a count and a sum.
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      ready_o <= 1'b0;
      count_o <= 8'h00;
      sum_o <= 16'h0000;
    end else begin
      ready_o <= slow_i ? ~ready_o : 1'b1;
      if (valid_i && ready_o) begin
        count_o <= count_o + 8'h01;
        sum_o <= sum_o + {8'h00, char_i};
      end
    end
  end
endmodule // echo_sink_model

// [tb/tb_top.sv]
// Self-checking bench of the command-mode settings block.
// Assumes the design's clock enable may stay high throughout.
`timescale 1ns/10ps
`define CHK(n, e, s) begin comparisons++; if ((s) !== (e)) begin fails++; \
  $display("MISMATCH %s exp %0h got %0h", n, e, s); end end
module tb_top;
  logic mclk_i = 0, reset_i = 1, cmd_valid_i = 0, char_valid_i = 0;
  logic slow = 0, tx_start_i = 0, stream_active_i = 0, stream_gap_i = 0;
  logic rx_error_evt_i = 0, rx_good_evt_i = 0, peer_valid_i = 0;
  logic [7:0] char_i = 8'h00;
  logic [6:0] key_digits_i = 7'h00;
  logic [255:0] key_value_i = '0;
  logic [15:0] rx_fill_i = 16'h0000, peer_id_i = 16'h0000;
  logic [3:0] peer_channel_i = 4'h0;
  modem_cfg_pkg::cmd_t cmd_i = '0;
  modem_cfg_pkg::resp_t resp_o;
  wire echo_valid_o, echo_ready, char_ready_o, pin_n, fv, init_full_o;
  wire init_wakeup_o, peer_accept_o, encrypt_en_o;
  wire [7:0] echo_char_o, fc, wake_len_o, iv_extra_o, count;
  wire [15:0] sum, net_id;
  wire [3:0] hop;
  logic cmd_mode = 1, sleep_cyc = 0, sleep_int = 0, wake_det = 0;
  wire listen, awake;
  wire [255:0] key;
  int fails = 0, comparisons = 0, full_n = 0, wake_n = 0;
  logic [7:0] last_flow = 8'h00;
  always #4 mclk_i = ~mclk_i;
  // Counts initializer pulses and keeps the last flow character sent.
  always @(negedge mclk_i) begin
    if (init_full_o === 1'b1) full_n++;
    if (init_wakeup_o === 1'b1) wake_n++;
    if (fv === 1'b1) last_flow <= fc;
  end
  modem_cmd_settings #(.TICK_CYCLES(10)) i_modem_cmd_settings (
    .mclk_i(mclk_i), .reset_i(reset_i), .ce_i(1'b1),
    .cmd_valid_i(cmd_valid_i), .cmd_i(cmd_i), .key_digits_i(key_digits_i),
    .key_value_i(key_value_i), .resp_o(resp_o), .cmd_mode_i(cmd_mode),
    .char_valid_i(char_valid_i), .char_i(char_i),
    .char_ready_o(char_ready_o), .echo_valid_o(echo_valid_o),
    .echo_char_o(echo_char_o), .echo_ready_i(echo_ready),
    .rx_fill_i(rx_fill_i), .flow_output_pin_n_o(pin_n),
    .flow_char_valid_o(fv), .flow_char_o(fc),
    .rx_error_evt_i(rx_error_evt_i), .rx_good_evt_i(rx_good_evt_i),
    .stream_active_i(stream_active_i), .stream_gap_i(stream_gap_i),
    .activity_i(1'b0), .tx_start_i(tx_start_i), .init_full_o(init_full_o),
    .init_wakeup_o(init_wakeup_o), .wake_len_o(wake_len_o),
    .peer_valid_i(peer_valid_i), .peer_channel_i(peer_channel_i),
    .peer_id_i(peer_id_i), .peer_accept_o(peer_accept_o),
    .sleep_cyclic_i(sleep_cyc), .sleep_interval_i(sleep_int),
    .wake_detect_i(wake_det), .listen_o(listen), .stay_awake_o(awake),
    .hop_channel_o(hop),
    .network_identifier_o(net_id), .encrypt_en_o(encrypt_en_o),
    .cipher_key_o(key), .iv_extra_o(iv_extra_o));
  echo_sink_model i_echo_sink_model (.mclk_i(mclk_i), .reset_i(reset_i),
    .slow_i(slow), .valid_i(echo_valid_o), .char_i(echo_char_o),
    .ready_o(echo_ready), .count_o(count), .sum_o(sum));
  // Prints the counts and the verdict, then ends the run.
  task stop_test();
    $display("checks %0d mismatches %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // Issues one command and checks the answer one cycle later.
  task cmd(input logic [7:0] c, input logic h, input logic [15:0] a,
           input logic e, input logic [15:0] d);
    @(negedge mclk_i) cmd_valid_i = 1;
    cmd_i = '{code: c, has_arg: h, arg: a};
    @(negedge mclk_i) cmd_valid_i = 0;
    `CHK("resp valid", 1'b1, resp_o.valid)
    `CHK("resp err", e, resp_o.err)
    `CHK("resp data", d, resp_o.data)
  endtask
  // Sends one character, held until the buffer has room.
  task chr(input logic [7:0] c);
    int k;
    @(negedge mclk_i) char_valid_i = 1;
    char_i = c;
    for (k = 0; k < 20 && char_ready_o !== 1'b1; k++) @(negedge mclk_i);
    if (k == 20) begin fails++; stop_test(); end
    @(negedge mclk_i) char_valid_i = 0;
  endtask
  // Pulses one packet event n times, good or error.
  task ev(input logic g, input int n);
    repeat (n) begin
      @(negedge mclk_i) {rx_good_evt_i, rx_error_evt_i} = {g, ~g};
      @(negedge mclk_i) {rx_good_evt_i, rx_error_evt_i} = 2'b00;
    end
    @(negedge mclk_i);
  endtask
  // Starts one transmission and lets its pulses land.
  task tx();
    @(negedge mclk_i) tx_start_i = 1;
    @(negedge mclk_i) tx_start_i = 0;
    repeat (2) @(negedge mclk_i);
  endtask
  // Offers a peer and checks acceptance one cycle later.
  task peer(input logic [3:0] ch, input logic [15:0] id, input logic x);
    @(negedge mclk_i) {peer_valid_i, peer_channel_i} = {1'b1, ch};
    peer_id_i = id;
    @(negedge mclk_i) peer_valid_i = 0;
    `CHK("peer accept", x, peer_accept_o)
  endtask
  initial begin
    repeat (2) @(negedge mclk_i);
    reset_i = 0;
    `CHK("hop", 4'h0, hop)
    `CHK("net id", 16'h0123, net_id)
    `CHK("wake len", 8'h01, wake_len_o)
    cmd(8'h0F, 0, 16'h0000, 0, 16'h0000);
    ev(0, 2);
    cmd(8'h0F, 0, 16'h0000, 0, 16'h0002);
    cmd(8'h0F, 1, 16'hFFFE, 0, 16'h0000);
    ev(0, 2);
    cmd(8'h0F, 0, 16'h0000, 0, 16'hFFFF);
    ev(1, 3);
    cmd(8'h10, 0, 16'h0000, 0, 16'h0003);
    cmd(8'h10, 1, 16'hFFFF, 0, 16'h0000);
    ev(1, 1);
    cmd(8'h10, 0, 16'h0000, 0, 16'hFFFF);
    $display("test counters done");
    chr(8'h41);
    cmd(8'h0B, 0, 16'h0000, 0, 16'h0000);
    slow = 1;
    chr(8'h41); chr(8'h42); chr(8'h43); chr(8'h44);
    repeat (20) @(negedge mclk_i);
    `CHK("echo count", 8'h04, count)
    `CHK("echo sum", 16'h010A, sum)
    cmd_mode = 0;
    chr(8'h46);
    cmd_mode = 1;
    cmd(8'h0A, 1, 16'h0000, 0, 16'h0000);
    chr(8'h45);
    repeat (10) @(negedge mclk_i);
    `CHK("echo off", 8'h04, count)
    `CHK("echo off sum", 16'h010A, sum)
    $display("test echo done");
    cmd(8'h11, 1, 16'h0009, 0, 16'h0000);
    `CHK("hop set", 4'h9, hop)
    cmd(8'h11, 1, 16'h000A, 1, 16'h0000);
    cmd(8'h27, 1, 16'h0010, 1, 16'h0000);
    cmd(8'h27, 1, 16'h8000, 1, 16'h0000);
    cmd(8'h27, 1, 16'h7FFF, 0, 16'h0000);
    peer(4'h9, 16'h7FFF, 1'b1);
    peer(4'h8, 16'h7FFF, 1'b0);
    peer(4'h9, 16'h0011, 1'b0);
    {key_digits_i, key_value_i} = {7'h3F, 256'h1};
    cmd(8'h3C, 1, 16'h0000, 1, 16'h0000);
    cmd(8'h3C, 0, 16'h0000, 1, 16'h0000);
    key_digits_i = 7'h40;
    cmd(8'h3C, 1, 16'h0000, 0, 16'h0000);
    `CHK("encrypt on", 1'b1, encrypt_en_o)
    `CHK("iv bytes", 8'h10, iv_extra_o)
    `CHK("key", 256'h1, key)
    {key_digits_i, key_value_i} = {7'h01, 256'h0};
    cmd(8'h3C, 1, 16'h0000, 0, 16'h0000);
    `CHK("encrypt off", 1'b0, encrypt_en_o)
    $display("test settings done");
    rx_fill_i = 16'h00EF;
    repeat (3) @(negedge mclk_i);
    `CHK("cts stop", 1'b1, pin_n)
    rx_fill_i = 16'h00EE;
    cmd(8'h07, 1, 16'h0002, 1, 16'h0000);
    cmd(8'h07, 1, 16'h0001, 0, 16'h0000);
    rx_fill_i = 16'h00EF;
    repeat (3) @(negedge mclk_i);
    `CHK("pause char", 8'h13, last_flow)
    `CHK("cts soft", 1'b0, pin_n)
    rx_fill_i = 16'h0000;
    repeat (3) @(negedge mclk_i);
    `CHK("resume char", 8'h11, last_flow)
    $display("test flow done");
    tx();
    `CHK("first init", 1, full_n)
    stream_active_i = 1;
    tx();
    `CHK("stream first", 2, full_n)
    tx();
    `CHK("stream init", 2, full_n)
    @(negedge mclk_i) stream_gap_i = 1;
    @(negedge mclk_i) stream_gap_i = 0;
    tx();
    `CHK("gap init", 3, full_n)
    cmd(8'h0D, 0, 16'h0000, 0, 16'h0000);
    tx();
    `CHK("no wake", 0, wake_n)
    cmd(8'h03, 1, 16'hFFFE, 0, 16'h0000);
    cmd(8'h0D, 0, 16'h0000, 0, 16'h0000);
    tx();
    `CHK("forced wake", 1, wake_n)
    $display("test initializer done");
    sleep_cyc = 1;
    @(negedge mclk_i) sleep_int = 1;
    @(negedge mclk_i) sleep_int = 0;
    `CHK("listen", 1'b1, listen)
    `CHK("awake early", 1'b0, awake)
    wake_det = 1;
    @(negedge mclk_i) `CHK("awake", 1'b1, awake)
    sleep_cyc = 0;
    wake_det = 0;
    @(negedge mclk_i) `CHK("asleep", 1'b0, awake)
    $display("test sleep done");
    stop_test();
  end
endmodule // tb_top
